// ### shared/sfb_pkg.sv
package sfb_pkg;
  // Clocking of the serial link
  localparam int SYS_CLK_HZ = 50_000_000;
  localparam int MAX_SCK_HZ = 25_000_000;
  localparam int DEF_SCK_HZ = 8_100_000;

  localparam int DIV_W  = 6;
  localparam int GAP_W  = 4;
  localparam int GAPC_W = GAP_W + DIV_W;
  localparam int ADDR_W = 28;
  localparam int CS_N   = 4;
  localparam int CS_LSB = 24;
  localparam int HDR_W  = 48;
  localparam int CNT_W  = 6;

  localparam logic [DIV_W-1:0] DIV_MIN   = DIV_W'((SYS_CLK_HZ + MAX_SCK_HZ - 1) / MAX_SCK_HZ);
  localparam logic [DIV_W-1:0] DIV_RESET = DIV_W'((SYS_CLK_HZ + DEF_SCK_HZ / 2) / DEF_SCK_HZ);
  localparam logic [GAP_W-1:0] GAP_RESET = 4'hF;
  localparam logic             WIDE_RESET = 1'h0;
  localparam logic             FAST_RESET = 1'h0;

  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_FAST = 8'h0B;

  localparam logic [CNT_W-1:0] CMD_BITS   = 6'h08;
  localparam logic [CNT_W-1:0] A24_BITS   = 6'h18;
  localparam logic [CNT_W-1:0] A32_BITS   = 6'h20;
  localparam logic [CNT_W-1:0] DUMMY_BITS = 6'h08;
  localparam logic [CNT_W-1:0] WORD_BITS  = 6'h20;

  localparam logic [ADDR_W-1:0] WORD_STEP = 28'h0000004;
  localparam logic [1:0]        SZ_BYTE   = 2'h0;
  localparam logic [1:0]        SZ_HALF   = 2'h1;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_GAP  = 5'h02,
    ST_HDR  = 5'h04,
    ST_DATA = 5'h08,
    ST_HOLD = 5'h10
  } sfb_state_t;
endpackage

// ### logic/sfb_sck_gen.sv
`timescale 1ns/100ps
module sfb_sck_gen
(
  input  wire logic                     clk,
  input  wire logic                     reset_n,
  input  wire logic                     run,
  input  wire logic [sfb_pkg::DIV_W-1:0] div,
  output logic                          sck,
  output logic                          fall_due
);
  import sfb_pkg::*;

  if (DIV_W < 2) begin : g_bad_width
    $error("sfb_sck_gen: divider too narrow");
  end

  typedef struct packed {
    logic             sck;
    logic [DIV_W-1:0] cnt;
  } sfb_gen_t;

  sfb_gen_t q;
  sfb_gen_t next_q;
  logic [DIV_W-1:0] low_len;
  logic [DIV_W-1:0] high_len;

  // Odd divides give the extra cycle to the high phase
  assign low_len  = div >> 1;
  assign high_len = div - low_len;
  assign sck      = q.sck;
  assign fall_due = run && q.sck && (q.cnt == DIV_W'(1));

  always_comb
  begin
    next_q = q;
    if (!run)
    begin
      next_q.sck = 1'b0;
      next_q.cnt = low_len;
    end
    else if (q.cnt == DIV_W'(1))
    begin
      next_q.sck = ~q.sck;
      next_q.cnt = q.sck ? low_len : high_len;
    end
    else
    begin
      next_q.cnt = q.cnt - DIV_W'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= next_q;
  end
endmodule // sfb_sck_gen

// ### logic/sfb_boot_reader.sv
// Functional notes
// RQ1 - Default 24-bit addressing, four selects, each owning a 16 MB window.
// RQ2 - Wide address mode maps the whole 256 MB region onto select 0.
// RQ3 - A read inside a select's window starts a flash read on that select.
// RQ4 - Accept 8, 16, 32-bit reads, single or burst; never write flash.
// RQ5 - Manual takeover: clock, data out, selects and enables follow software.
// RQ6 - Serial data input level is readable as a status bit.
// RQ7 - Selects are active low; at most one asserted at a time.
// RQ8 - After fetching an address, prefetch the next sequential one.
// RQ9 - Wide mode shifts 32 address bits instead of 24.
// RQ10 - Quick read enable issues the fast read command.
// RQ11 - Select stays high between accesses for a programmed count of periods.
// RQ12 - Serial clock is the system clock through the programmable divider.
// RQ13 - Software writes the divider last or together with other fields.
// RQ14 - Reconfiguration during boot reads must not corrupt ongoing fetches.
// RQ15 - Defaults: about 8.1 MHz, normal reads, maximum select gap.
// RQ16 - Sample data input just before driving each falling clock edge.
// RQ17 - Software does not fetch from flash while driving pins manually.
// RQ18 - Boot starts in 24-bit mode, then switches flash and block to wide.
// RQ19 - Transaction: select, command, address MSB first, dummy if fast, data.
// RQ20 - A read missing the prefetched word or select restarts a transaction.
`timescale 1ns/100ps
module sfb_boot_reader
(
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  input  wire logic                       rd_req,
  input  wire logic [sfb_pkg::ADDR_W-1:0] rd_addr,
  input  wire logic [1:0]                 rd_size,
  output logic                            rd_ack,
  output logic [31:0]                     rd_data,
  input  wire logic [sfb_pkg::DIV_W-1:0]  clk_div,
  input  wire logic                       quick_read_enable,
  input  wire logic [sfb_pkg::GAP_W-1:0]  select_gap_time,
  input  wire logic                       wide_address_enable,
  input  wire logic                       manual_pin_takeover,
  input  wire logic                       manual_sck,
  input  wire logic                       manual_sck_oe,
  input  wire logic                       manual_data_out,
  input  wire logic                       manual_data_out_oe,
  input  wire logic [sfb_pkg::CS_N-1:0]   manual_select_n,
  input  wire logic [sfb_pkg::CS_N-1:0]   manual_select_oe,
  output logic                            manual_input_level,
  output logic                            flash_sck,
  output logic                            flash_sck_oe,
  output logic                            flash_data_out,
  output logic                            flash_data_out_oe,
  output logic [sfb_pkg::CS_N-1:0]        flash_select_n,
  output logic [sfb_pkg::CS_N-1:0]        flash_select_oe,
  input  wire logic                       serial_data_in
);
  import sfb_pkg::*;

  typedef struct packed {
    sfb_state_t        st;
    logic [1:0]        cs;
    logic [ADDR_W-1:0] addr;
    logic [HDR_W-1:0]  sh;
    logic [CNT_W-1:0]  bits;
    logic [31:0]       word;
    logic [31:0]       buf_word;
    logic [GAPC_W-1:0] gapc;
    logic [DIV_W-1:0]  div;
    logic              fast;
    logic              wide;
    logic              ack;
    logic [31:0]       data;
    logic              sync1;
    logic              sync2;
    logic              sck;
    logic              sck_oe;
    logic              dout;
    logic              dout_oe;
    logic [CS_N-1:0]   sel_n;
    logic [CS_N-1:0]   sel_oe;
  } sfb_main_t;

  sfb_main_t q;
  sfb_main_t next_q;
  logic      gen_sck;
  logic      fall_due;
  logic      hit;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [1:0] cs_of(input logic [ADDR_W-1:0] a, input logic wide);
    cs_of = wide ? 2'h0 : a[CS_LSB +: 2]; // RQ1 RQ2
  endfunction

  function automatic logic [HDR_W-1:0] header(input logic [ADDR_W-1:0] a,
                                              input logic wide, input logic fast);
    logic [7:0] cmd;
    cmd = fast ? CMD_FAST : CMD_READ; // RQ10
    if (wide)
      header = {cmd, 4'h0, a, 8'h00}; // RQ9
    else
      header = {cmd, a[23:0], 16'h0000};
  endfunction

  function automatic logic [31:0] lane_mask(input logic [1:0] size, input logic [1:0] a);
    unique case (size)
      SZ_BYTE: lane_mask = 32'h000000FF << {a, 3'h0};
      SZ_HALF: lane_mask = 32'h0000FFFF << {a[1], 4'h0};
      default: lane_mask = 32'hFFFFFFFF;
    endcase
  endfunction

  function automatic logic [CS_N-1:0] one_low(input logic [CS_N-1:0] sel_n);
    logic [CS_N-1:0] act;
    act = ~sel_n;
    one_low = ~(act & (~act + CS_N'(1))); // RQ7
  endfunction

  function automatic logic [DIV_W-1:0] clamp_div(input logic [DIV_W-1:0] d);
    clamp_div = (d < DIV_MIN) ? DIV_MIN : d; // RQ12
  endfunction

  // Config is taken only between transactions, so a write mid-fetch waits
  function automatic sfb_main_t latch_cfg(input sfb_main_t s);
    sfb_main_t r;
    r = s;
    r.div  = clamp_div(clk_div); // RQ13 RQ14
    r.fast = quick_read_enable;
    r.wide = wide_address_enable;
    return r;
  endfunction

  function automatic sfb_main_t start_fetch(input sfb_main_t s);
    sfb_main_t r;
    r = s;
    r.st   = ST_HDR; // RQ3 RQ19
    r.cs   = cs_of(rd_addr, r.wide);
    r.addr = {rd_addr[ADDR_W-1:2], 2'h0};
    r.sh   = header(r.addr, r.wide, r.fast);
    r.bits = CMD_BITS + (r.wide ? A32_BITS : A24_BITS) + (r.fast ? DUMMY_BITS : 6'h00);
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  sfb_sck_gen u_sck_gen
  (
    .clk      (clk),
    .reset_n  (reset_n),
    .run      (q.st == ST_HDR || q.st == ST_DATA),
    .div      (q.div),
    .sck      (gen_sck),
    .fall_due (fall_due)
  );

  assign hit = (rd_addr[ADDR_W-1:2] == q.addr[ADDR_W-1:2])
            && (cs_of(rd_addr, wide_address_enable) == q.cs); // RQ20

  always_comb
  begin
    next_q       = q;
    next_q.ack   = 1'b0;
    next_q.sync1 = serial_data_in;
    next_q.sync2 = q.sync1;
    unique case (q.st)
      ST_IDLE:
      begin
        next_q = latch_cfg(next_q);
        if (rd_req)
          next_q = start_fetch(next_q);
      end
      ST_GAP:
      begin
        if (q.gapc <= GAPC_W'(1))
          next_q = start_fetch(next_q);
        else
          next_q.gapc = q.gapc - GAPC_W'(1); // RQ11
      end
      ST_HDR:
      begin
        if (fall_due)
        begin
          next_q.sh   = q.sh << 1;
          next_q.bits = q.bits - CNT_W'(1);
          if (q.bits == CNT_W'(1))
          begin
            next_q.st   = ST_DATA;
            next_q.bits = WORD_BITS;
          end
        end
      end
      ST_DATA:
      begin
        // Sample point is the cycle before the clock is driven low
        if (fall_due)
        begin
          next_q.word = {q.word[30:0], q.sync2}; // RQ16
          next_q.bits = q.bits - CNT_W'(1);
          if (q.bits == CNT_W'(1))
          begin
            next_q.st       = ST_HOLD;
            next_q.buf_word = {q.word[6:0], q.sync2, q.word[14:7],
                               q.word[22:15], q.word[30:23]};
          end
        end
      end
      ST_HOLD:
      begin
        // Select stays low with the clock parked, so a hit just resumes
        if (rd_req && hit)
        begin
          next_q.ack  = 1'b1;
          next_q.data = q.buf_word & lane_mask(rd_size, rd_addr[1:0]); // RQ4
          next_q.st   = ST_DATA; // RQ8
          next_q.bits = WORD_BITS;
          next_q.addr = q.addr + WORD_STEP;
        end
        else if (rd_req)
        begin
          next_q      = latch_cfg(next_q);
          next_q.st   = ST_GAP; // RQ20
          next_q.gapc = GAPC_W'(select_gap_time) * GAPC_W'(next_q.div); // RQ11
        end
      end
    endcase

    // Requests stall while software owns the pins
    if (manual_pin_takeover)
    begin
      next_q.st  = ST_IDLE; // RQ17
      next_q.ack = 1'b0;
    end

    if (manual_pin_takeover)
    begin
      next_q.sck     = manual_sck; // RQ5
      next_q.sck_oe  = manual_sck_oe;
      next_q.dout    = manual_data_out;
      next_q.dout_oe = manual_data_out_oe;
      next_q.sel_n   = one_low(manual_select_n); // RQ7
      next_q.sel_oe  = manual_select_oe;
    end
    else
    begin
      next_q.sck     = gen_sck && (q.st == ST_HDR || q.st == ST_DATA);
      next_q.sck_oe  = 1'b1;
      next_q.dout    = (q.st == ST_HDR) && q.sh[HDR_W-1]; // RQ19
      next_q.dout_oe = 1'b1;
      next_q.sel_oe  = '1;
      if (q.st == ST_HDR || q.st == ST_DATA || q.st == ST_HOLD)
        next_q.sel_n = ~(CS_N'(1) << q.cs); // RQ3 RQ7
      else
        next_q.sel_n = '1; // RQ11
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      q         <= '0;
      q.st      <= ST_IDLE;
      q.div     <= DIV_RESET; // RQ15
      q.fast    <= FAST_RESET;
      q.wide    <= WIDE_RESET;
      q.sck_oe  <= 1'b1;
      q.dout_oe <= 1'b1;
      q.sel_n   <= '1;
      q.sel_oe  <= '1;
    end
    else
      q <= next_q;
  end

  assign rd_ack             = q.ack;
  assign rd_data            = q.data;
  assign manual_input_level = q.sync2; // RQ6
  assign flash_sck          = q.sck;
  assign flash_sck_oe       = q.sck_oe;
  assign flash_data_out     = q.dout;
  assign flash_data_out_oe  = q.dout_oe;
  assign flash_select_n     = q.sel_n;
  assign flash_select_oe    = q.sel_oe;

  ////////////////////////////////////////////////////////////////////////////
  logic [CNT_W-1:0] chk_falls;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      chk_falls <= '0;
    else if (q.st != ST_HDR)
      chk_falls <= '0;
    else if (fall_due)
      chk_falls <= chk_falls + CNT_W'(1);
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_hold_hit;
    q.st == ST_HOLD && rd_req && hit && !manual_pin_takeover;
  endsequence

  sequence s_hold_miss;
    q.st == ST_HOLD && rd_req && !hit && !manual_pin_takeover;
  endsequence

  sequence s_next_fetch;
    rd_ack && q.st == ST_DATA && q.bits == WORD_BITS && q.addr == $past(q.addr) + WORD_STEP;
  endsequence

  a_cs_single: assert property ($countones(~flash_select_n) <= 1) // RQ7
    else $error("more than one flash select asserted");

  a_wide_cs0: assert property ((q.st == ST_HDR && q.wide && !manual_pin_takeover) // RQ2
    |=> flash_select_n[CS_N-1:1] == '1 && !flash_select_n[0])
    else $error("wide mode used a select other than 0");

  a_cs_window: assert property ((q.st == ST_HDR && !q.wide && !manual_pin_takeover) // RQ1 RQ3
    |=> flash_select_n == ~(CS_N'(1) << q.addr[CS_LSB +: 2]))
    else $error("select does not match address window");

  a_manual_follow: assert property (manual_pin_takeover // RQ5
    |=> flash_sck == $past(manual_sck) && flash_data_out == $past(manual_data_out)
        && flash_sck_oe == $past(manual_sck_oe) && flash_select_oe == $past(manual_select_oe))
    else $error("pins do not follow manual values");

  a_input_level: assert property ($past(reset_n, 2) // RQ6
    |-> manual_input_level == $past(serial_data_in, 2))
    else $error("input level status wrong");

  a_cmd_byte: assert property ($rose(q.st == ST_HDR) // RQ10
    |-> q.sh[HDR_W-1 -: 8] == (q.fast ? CMD_FAST : CMD_READ))
    else $error("wrong read command");

  a_header_len: assert property ((q.st == ST_HDR && fall_due && q.bits == CNT_W'(1)) // RQ9 RQ19
    |-> chk_falls + CNT_W'(1) == CMD_BITS + (q.wide ? A32_BITS : A24_BITS)
        + (q.fast ? DUMMY_BITS : 6'h00))
    else $error("header bit count wrong");

  a_prefetch_next: assert property (s_hold_hit |=> s_next_fetch) // RQ8
    else $error("hit did not answer and prefetch next word");

  a_miss_restart: assert property (s_hold_miss // RQ11 RQ20
    |=> q.st == ST_GAP && !rd_ack && q.gapc == GAPC_W'($past(select_gap_time)) * GAPC_W'(q.div))
    else $error("miss did not restart through gap");

  a_sample_fall: assert property ((q.st == ST_DATA && fall_due) ##1 !manual_pin_takeover // RQ16
    |=> !flash_sck)
    else $error("sample not followed by falling clock");

  a_cfg_stable: assert property ((q.st == ST_HDR || q.st == ST_DATA) // RQ14
    |=> $stable(q.div) && $stable(q.wide) && $stable(q.fast))
    else $error("config changed inside a transaction");
endmodule // sfb_boot_reader

// ### tb/sfb_flash_model.sv
`timescale 1ns/100ps
module sfb_flash_model
(
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic [3:0] select_n,
  input  wire logic       wide,
  output logic            miso
);
  logic [7:0]  cmd;
  logic [31:0] addr;
  logic [1:0]  sel;
  logic [7:0]  cur;
  int          nbit;
  int          k;
  wire         active = (select_n != 4'hF);

  function automatic logic [7:0] fb(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ a[31:24] ^ 8'h3C;
  endfunction

  initial miso = 1'b0;

  ////////////////////////////////////////////////////////////////
  // Released line flips, so a stale bit is never mistaken for data
  always @(active)
  begin
    nbit = 0;
    addr = 32'h0;
    if (!active)
      miso = ~miso;
    for (int i = 3; i >= 0; i--)
      if (!select_n[i])
        sel = 2'(i);
  end

  always @(posedge sck)
    if (active)
    begin
      if (nbit < 8)
        cmd = {cmd[6:0], mosi};
      else if (nbit < 8 + (wide ? 32 : 24))
        addr = {addr[30:0], mosi};
      nbit++;
    end

  // Dummy byte skipped for the quick command; bytes stream on
  always @(negedge sck)
  begin
    k = nbit - 8 - (wide ? 32 : 24) - ((cmd == 8'h0B) ? 8 : 0);
    if (active && k >= 0)
    begin
      cur = fb(addr + 32'(k / 8));
      miso = cur[7 - k % 8];
    end
  end
endmodule // sfb_flash_model

// ### tb/serial_flash_boot_reader_test.sv
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module serial_flash_boot_reader_test;
  import sfb_pkg::*;
  logic              clk;
  logic              reset_n;
  logic              rd_req;
  logic [ADDR_W-1:0] rd_addr;
  logic [1:0]        rd_size;
  logic              rd_ack;
  logic [31:0]       rd_data;
  logic [DIV_W-1:0]  clk_div;
  logic              quick;
  logic [GAP_W-1:0]  gap;
  logic              wide;
  logic              take;
  logic [3:0]        man;
  logic [3:0]        man_sel_n;
  logic [3:0]        man_sel_oe;
  logic              level;
  logic              sck;
  logic              sck_oe;
  logic              dout;
  logic              dout_oe;
  logic [3:0]        sel_n;
  logic [3:0]        sel_oe;
  logic              sdi;
  logic              sck_q;
  int                err_count;
  int                cmp_count;
  int                cyc;
  int                hi_run;
  int                gap_seen;
  int                sck_cnt;
  int                sck_per;

  sfb_boot_reader DUT (.clk(clk), .reset_n(reset_n), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_size(rd_size), .rd_ack(rd_ack), .rd_data(rd_data),
    .clk_div(clk_div), .quick_read_enable(quick), .select_gap_time(gap),
    .wide_address_enable(wide), .manual_pin_takeover(take), .manual_sck(man[3]),
    .manual_sck_oe(man[2]), .manual_data_out(man[1]), .manual_data_out_oe(man[0]),
    .manual_select_n(man_sel_n), .manual_select_oe(man_sel_oe),
    .manual_input_level(level), .flash_sck(sck), .flash_sck_oe(sck_oe),
    .flash_data_out(dout), .flash_data_out_oe(dout_oe), .flash_select_n(sel_n),
    .flash_select_oe(sel_oe), .serial_data_in(sdi));

  sfb_flash_model flash (.sck(sck), .mosi(dout), .select_n(sel_n), .wide(wide),
    .miso(sdi));

  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Gap, serial period and hang watch, all in system cycles
  always @(posedge clk)
  begin
    cyc++;
    if (sel_n != 4'hF && hi_run > 0)
      gap_seen = hi_run;
    hi_run = (sel_n == 4'hF) ? hi_run + 1 : 0;
    sck_cnt++;
    if (sck && !sck_q)
    begin
      if (sck_cnt < 64)
        sck_per = sck_cnt;
      sck_cnt = 0;
    end
    sck_q = sck;
    if (cyc == 40000)
    begin
      err_count++;
      final_report();
    end
  end

  function automatic logic [31:0] expw(input logic [31:0] fa, input logic [1:0] sz);
    logic [31:0] b;
    logic [31:0] w;
    b = {fa[31:2], 2'h0};
    w = {flash.fb(b + 3), flash.fb(b + 2), flash.fb(b + 1), flash.fb(b)};
    if (sz == 2'h0)
      return w & (32'hFF << {fa[1:0], 3'h0});
    if (sz == 2'h1)
      return w & (32'hFFFF << {fa[1], 4'h0});
    return w;
  endfunction

  task automatic rd(input logic [27:0] a, input logic [1:0] sz, output int n);
    logic [31:0] fa;
    n = 0;
    @(posedge clk);
    rd_req <= 1'b1;
    rd_addr <= a;
    rd_size <= sz;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rd_ack !== 1'b1 && n < 3000);
    rd_req <= 1'b0;
    // Mode read late, so a same-edge change of the wide input is seen
    fa = wide ? {4'h0, a} : {8'h0, a[23:0]};
    `CHK("rd_ack", 1'b1, rd_ack);
    `CHK("rd_data", expw(fa, sz), rd_data);
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_cold();
    int n;
    `CHK("sel_n", 4'hF, sel_n);
    `CHK("rd_ack", 1'b0, rd_ack);
    rd(28'h0000010, 2'h2, n);
    `CHK("cmd", 8'h03, flash.cmd);
    `CHK("addr", 32'h10, flash.addr);
    `CHK("sel", 2'h0, flash.sel);
    `CHK("period", 6, sck_per);
    repeat (500) @(posedge clk);
    rd(28'h0000014, 2'h2, n);
    `CHK("hit", 1'b1, n < 5);
  endtask

  task automatic t_sel();
    int n;
    for (int cs = 1; cs < 4; cs++)
    begin
      rd({cs[3:0], 24'h000120}, 2'h2, n);
      `CHK("sel", cs[1:0], flash.sel);
      `CHK("addr", 32'h120, flash.addr);
    end
  endtask

  task automatic t_size();
    int n;
    logic [27:0] ta [4] = '{28'h301, 28'h302, 28'h303, 28'h300};
    logic [1:0]  ts [4] = '{2'h0, 2'h1, 2'h0, 2'h3};
    for (int i = 0; i < 4; i++)
      rd(ta[i], ts[i], n);
  endtask

  // First pass keeps the reset gap and divider
  task automatic t_gap();
    int n;
    logic [3:0] g [2] = '{4'hF, 4'h2};
    logic [5:0] dv [2] = '{6'h06, 6'h04};
    for (int i = 0; i < 2; i++)
    begin
      gap <= g[i];
      clk_div <= dv[i];
      rd(28'h0000400 + 28'(i * 64), 2'h2, n);
      rd(28'h0000800 + 28'(i * 64), 2'h2, n);
      `CHK("gap_min", 1'b1, gap_seen >= g[i] * dv[i]);
      `CHK("gap_max", 1'b1, gap_seen <= g[i] * dv[i] + 4);
      `CHK("period", int'(dv[i]), sck_per);
    end
  endtask

  task automatic t_fast();
    int n;
    quick <= 1'b1;
    rd(28'h0000500, 2'h2, n);
    `CHK("cmd", 8'h0B, flash.cmd);
    `CHK("addr", 32'h500, flash.addr);
    repeat (300) @(posedge clk);
    // Divider goes in the same write as the rest
    quick <= 1'b0;
    clk_div <= 6'h05;
    rd(28'h0000504, 2'h2, n);
    rd(28'h0000508, 2'h2, n);
    rd(28'h0000600, 2'h2, n);
    `CHK("cmd", 8'h03, flash.cmd);
    `CHK("period", 5, sck_per);
  endtask

  task automatic t_wide();
    int n;
    wide <= 1'b1;
    rd(28'h3000020, 2'h2, n);
    `CHK("sel", 2'h0, flash.sel);
    `CHK("addr", 32'h03000020, flash.addr);
    wide <= 1'b0;
  endtask

  task automatic t_manual();
    take <= 1'b1;
    man <= 4'b1011;
    // Two selects low at once: only the lowest may reach the pins
    man_sel_n <= 4'b1010;
    man_sel_oe <= 4'b0011;
    repeat (6) @(posedge clk);
    `CHK("pins", 4'b1011, {sck, sck_oe, dout, dout_oe});
    `CHK("sel_n", 4'b1110, sel_n);
    `CHK("sel_oe", 4'b0011, sel_oe);
    `CHK("level", sdi, level);
    man <= 4'b0100;
    man_sel_n <= 4'b1101;
    repeat (6) @(posedge clk);
    `CHK("pins", 4'b0100, {sck, sck_oe, dout, dout_oe});
    `CHK("sel_n", 4'b1101, sel_n);
    `CHK("level", sdi, level);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    reset_n = 1'b0;
    rd_req = 1'b0;
    rd_addr = '0;
    rd_size = 2'h2;
    clk_div = 6'h06;
    quick = 1'b0;
    gap = 4'hF;
    wide = 1'b0;
    take = 1'b0;
    man = 4'h0;
    man_sel_n = 4'hF;
    man_sel_oe = 4'hF;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_cold();
    t_sel();
    t_size();
    t_gap();
    t_fast();
    t_wide();
    t_manual();
    final_report();
  end
endmodule // serial_flash_boot_reader_test
